// ===== logic/tsch_consts.vh
// Constants for the task request scheduler.
`ifndef TSCH_CONSTS_VH
`define TSCH_CONSTS_VH
`define TSCH_CLK_NS 25
`define TSCH_MS_NS 1000000
`define TSCH_MS_CYCLES (`TSCH_MS_NS / `TSCH_CLK_NS)
`define TSCH_CNT_CHK_US 250
`define TSCH_CNT_CHK_CYCLES ((`TSCH_CNT_CHK_US * 1000) / `TSCH_CLK_NS)
`define TSCH_EXT_DET_US 50
`define TSCH_NFIX 16
`define TSCH_EXT_BASE 16
`define TSCH_NEXT 8
`define TSCH_INT_BASE 24
`define TSCH_NINT 16
`define TSCH_CNT_BASE 40
`define TSCH_REG_CTRL 2'h0
`define TSCH_REG_CFG 2'h1
`define TSCH_REG_PERIOD 2'h2
`define TSCH_REG_SETV 2'h3
`define TSCH_IDX_CTRL 6'h00
`define TSCH_IDX_PEND_LO 6'h01
`define TSCH_IDX_PEND_HI 6'h02
`define TSCH_IDX_BUSY_LO 6'h03
`define TSCH_IDX_BUSY_HI 6'h04
`define TSCH_CFG_PRIO_LSB 0
`define TSCH_CFG_EN_BIT 3
`define TSCH_CFG_COND_LSB 4
`define TSCH_CFG_WORD_BIT 7
`define TSCH_CFG_SEL_LSB 8
`define TSCH_CFG_RESET 12'h007
`define TSCH_COND_RISE 3'h0
`define TSCH_COND_FALL 3'h1
`define TSCH_COND_BOTH 3'h2
`define TSCH_COND_ON 3'h3
`define TSCH_COND_OFF 3'h4
`define TSCH_CMP_LT 3'h0
`define TSCH_CMP_LE 3'h1
`define TSCH_CMP_EQ 3'h2
`define TSCH_CMP_GE 3'h3
`define TSCH_CMP_GT 3'h4
`endif

// ===== logic/tsch_sync.v
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
module tsch_sync #(
  parameter W = 8
) (
  // Clock and reset.
  input wire core_clk_i,
  input wire rst_n_i,
  // Data.
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] val_q;
  genvar i;

  assign q_o = val_q;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted once the second and third stages agree.
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          val_q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          val_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule

// ===== logic/tsch_arb.v
// Priority selector over pending task flags.
`timescale 1ns/100ps
module tsch_arb #(
  parameter NT = 44
) (
  // Candidates.
  input wire [NT-1:0] pend_i,
  input wire [3*NT-1:0] prio_i,
  // Winner.
  output reg found_o,
  output reg [5:0] idx_o
);
  reg [2:0] best;
  integer i;

  // Smaller priority value wins; a tie goes to the lower task number.
  always @* begin
    found_o = 1'b0;
    idx_o = 6'h00;
    best = 3'h7;
    for (i = 0; i < NT; i = i + 1) begin
      if (pend_i[i] && (!found_o || prio_i[3*i +: 3] < best)) begin
        found_o = 1'b1;
        idx_o = i[5:0];
        best = prio_i[3*i +: 3];
      end
    end
  end
endmodule

// ===== logic/tsch_scheduler.v
// Task request scheduler: raises, filters and arbitrates task starts.
// Notes on behaviour
// - A fixed task is requested each time its period elapses.
// - A fixed request is dropped while that task runs or is pending.
// - The period timer only advances in RUN and holds otherwise.
// - A contact task fires on rising, falling or either edge.
// - Eight contact inputs are bits eight to fifteen of input word 0.
// - A contact request is dropped while that task runs or is pending.
// - Contacts are watched for task starts only in RUN.
// - A qualifying contact edge raises its request within 50 us.
// - Bit device tasks fire on edges, or every scan while on or off.
// - Word device tasks fire on lt, le, eq, ge or gt against set value.
// - Device conditions are evaluated only at scan end.
// - Device conditions gone before scan end never fire.
// - A counter task fires when the count equals its setting 0.
// - Counter matches are checked every 250 us.
// - Counter requests are raised only in RUN.
// - The pending task with the smallest priority value is offered.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "tsch_consts.vh"
module tsch_scheduler #(
  parameter NCH = 4,
  parameter MS_CYCLES = `TSCH_MS_CYCLES,
  parameter CNT_CHK_CYCLES = `TSCH_CNT_CHK_CYCLES
) (
  // Clock and reset.
  input wire core_clk_i,
  input wire rst_n_i,
  // Register port.
  input wire [9:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [31:0] reg_rdata_o,
  // Input contacts and internal devices.
  input wire [15:0] in_word0_i,
  input wire [15:0] dev_bit_i,
  input wire [255:0] dev_word_i,
  input wire scan_end_i,
  // Counter channels.
  input wire [NCH*32-1:0] cnt_val_i,
  input wire [NCH*32-1:0] cnt_set0_i,
  // Task executor.
  output wire task_req_o,
  output wire [5:0] task_num_o,
  input wire task_ack_i,
  input wire task_done_i,
  input wire [5:0] task_done_num_i,
  output wire run_o
);
  localparam NT = `TSCH_CNT_BASE + NCH;
  localparam integer MS_LAST_I = MS_CYCLES - 1;
  localparam integer CHK_LAST_I = CNT_CHK_CYCLES - 1;
  localparam [15:0] MS_LAST = MS_LAST_I[15:0];
  localparam [15:0] CHK_LAST = CHK_LAST_I[15:0];

  reg run_q;
  reg [11:0] cfg_q [0:NT-1];
  reg [31:0] per_q [0:`TSCH_NFIX-1];
  reg [15:0] setv_q [0:`TSCH_NINT-1];
  reg [31:0] per_cnt_q [0:`TSCH_NFIX-1];
  reg [15:0] ms_cnt_q;
  reg [15:0] chk_cnt_q;
  reg [7:0] ext_prev_q;
  reg [`TSCH_NINT-1:0] int_prev_q;
  reg [NCH-1:0] eq_prev_q;
  reg [NT-1:0] pend_q;
  reg [NT-1:0] busy_q;
  reg req_q;
  reg [5:0] num_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg [63:0] pend_w;
  reg [63:0] busy_w;

  wire [7:0] ext_now;
  wire [NT-1:0] raw_req;
  wire [NT-1:0] accept;
  wire [NT-1:0] disp_clr;
  wire [NT-1:0] done_clr;
  wire [NT-1:0] pend_d;
  wire [NT-1:0] busy_d;
  wire [3*NT-1:0] prio_vec;
  wire [`TSCH_NINT-1:0] int_bit_now;
  wire ms_tick;
  wire chk_tick;
  wire arb_found;
  wire [5:0] arb_idx;
  wire [1:0] region;
  wire [5:0] idx;
  integer k;
  genvar i;

  assign reg_rdata_o = rdata_q;
  assign task_req_o = req_q;
  assign task_num_o = num_q;
  assign run_o = run_q;
  assign region = reg_addr_i[9:8];
  assign idx = reg_addr_i[7:2];
  assign ms_tick = (ms_cnt_q == MS_LAST);
  assign chk_tick = (chk_cnt_q == CHK_LAST);

  // Edge condition shared by contact and bit device tasks.
  function edge_hit;
    input [2:0] c;
    input now;
    input prev;
    begin
      case (c)
        `TSCH_COND_RISE: edge_hit = now & ~prev;
        `TSCH_COND_FALL: edge_hit = ~now & prev;
        `TSCH_COND_BOTH: edge_hit = now ^ prev;
        `TSCH_COND_ON: edge_hit = now;
        `TSCH_COND_OFF: edge_hit = ~now;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Word comparison against the set value.
  function word_hit;
    input [2:0] c;
    input [15:0] w;
    input [15:0] s;
    begin
      case (c)
        `TSCH_CMP_LT: word_hit = (w < s);
        `TSCH_CMP_LE: word_hit = (w <= s);
        `TSCH_CMP_EQ: word_hit = (w == s);
        `TSCH_CMP_GE: word_hit = (w >= s);
        `TSCH_CMP_GT: word_hit = (w > s);
        default: word_hit = 1'b0;
      endcase
    end
  endfunction

  // Contact pins cross in through the synchroniser.
  tsch_sync #(
    .W(8)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(in_word0_i[15:8]),
    .q_o(ext_now)
  );

  // Millisecond and counter-check prescalers.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_q <= 16'h0000;
      chk_cnt_q <= 16'h0000;
    end else begin
      if (!run_q || ms_tick) begin
        ms_cnt_q <= 16'h0000;
      end else begin
        ms_cnt_q <= ms_cnt_q + 16'h0001;
      end
      if (chk_tick) begin
        chk_cnt_q <= 16'h0000;
      end else begin
        chk_cnt_q <= chk_cnt_q + 16'h0001;
      end
    end
  end

  generate
    for (i = 0; i < NT; i = i + 1) begin : g_prio
      assign prio_vec[3*i +: 3] = cfg_q[i][2:0];
    end

    // Fixed-cycle tasks.
    for (i = 0; i < `TSCH_NFIX; i = i + 1) begin : g_fix
      wire hit;
      assign hit = run_q && ms_tick && per_q[i] != 32'h0 &&
                   per_cnt_q[i] >= per_q[i] - 32'h1;
      assign raw_req[i] = hit & cfg_q[i][`TSCH_CFG_EN_BIT];
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          per_cnt_q[i] <= 32'h0;
        end else if (run_q && ms_tick) begin
          if (hit || per_q[i] == 32'h0) begin
            per_cnt_q[i] <= 32'h0;
          end else begin
            per_cnt_q[i] <= per_cnt_q[i] + 32'h1;
          end
        end
      end
    end

    // External contact tasks.
    for (i = 0; i < `TSCH_NEXT; i = i + 1) begin : g_ext
      wire [2:0] sel;
      wire [2:0] cond;
      assign sel = cfg_q[`TSCH_EXT_BASE + i][10:8];
      assign cond = cfg_q[`TSCH_EXT_BASE + i][6:4];
      assign raw_req[`TSCH_EXT_BASE + i] = run_q &&
        cfg_q[`TSCH_EXT_BASE + i][`TSCH_CFG_EN_BIT] &&
        cond <= `TSCH_COND_BOTH &&
        edge_hit(cond, ext_now[sel], ext_prev_q[sel]);
    end

    // Internal device tasks, sampled only at scan end.
    for (i = 0; i < `TSCH_NINT; i = i + 1) begin : g_int
      wire [11:0] c;
      wire [15:0] w;
      assign c = cfg_q[`TSCH_INT_BASE + i];
      assign w = dev_word_i[{c[11:8], 4'h0} +: 16];
      assign int_bit_now[i] = dev_bit_i[c[11:8]];
      assign raw_req[`TSCH_INT_BASE + i] = scan_end_i && run_q &&
        c[`TSCH_CFG_EN_BIT] && (c[`TSCH_CFG_WORD_BIT] ?
        word_hit(c[6:4], w, setv_q[i]) :
        edge_hit(c[6:4], int_bit_now[i], int_prev_q[i]));
    end

    // Counter equality tasks, checked on the slow tick.
    for (i = 0; i < NCH; i = i + 1) begin : g_cnt
      wire eq;
      assign eq = (cnt_val_i[32*i +: 32] == cnt_set0_i[32*i +: 32]);
      assign raw_req[`TSCH_CNT_BASE + i] = chk_tick && run_q &&
        cfg_q[`TSCH_CNT_BASE + i][`TSCH_CFG_EN_BIT] &&
        eq && !eq_prev_q[i];
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          eq_prev_q[i] <= 1'b0;
        end else if (chk_tick) begin
          eq_prev_q[i] <= eq;
        end
      end
    end

    for (i = 0; i < NT; i = i + 1) begin : g_flag
      assign disp_clr[i] = task_ack_i && req_q && (num_q == i);
      assign done_clr[i] = task_done_i && (task_done_num_i == i);
    end
  endgenerate

  // Duplicates of a pending or running task are discarded.
  assign accept = raw_req & ~pend_q & ~busy_q;
  assign pend_d = (pend_q & ~disp_clr) | accept;
  assign busy_d = (busy_q & ~done_clr) | disp_clr;

  tsch_arb #(
    .NT(NT)
  ) u_arb (
    .pend_i(pend_d),
    .prio_i(prio_vec),
    .found_o(arb_found),
    .idx_o(arb_idx)
  );

  // Flags, offer and previous samples.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= {NT{1'b0}};
      busy_q <= {NT{1'b0}};
      req_q <= 1'b0;
      num_q <= 6'h00;
      ext_prev_q <= 8'h00;
      int_prev_q <= {`TSCH_NINT{1'b0}};
    end else begin
      pend_q <= pend_d;
      busy_q <= busy_d;
      req_q <= arb_found;
      num_q <= arb_idx;
      ext_prev_q <= ext_now;
      if (scan_end_i) begin
        int_prev_q <= int_bit_now;
      end
    end
  end

  // Register writes.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      for (k = 0; k < NT; k = k + 1) begin
        cfg_q[k] <= `TSCH_CFG_RESET;
      end
      for (k = 0; k < `TSCH_NFIX; k = k + 1) begin
        per_q[k] <= 32'h0;
        setv_q[k] <= 16'h0000;
      end
    end else if (reg_wr_i) begin
      case (region)
        `TSCH_REG_CTRL: begin
          if (idx == `TSCH_IDX_CTRL) begin
            run_q <= reg_wdata_i[0];
          end
        end
        `TSCH_REG_CFG: begin
          if (idx < NT) begin
            cfg_q[idx] <= reg_wdata_i[11:0];
          end
        end
        `TSCH_REG_PERIOD: begin
          if (idx < `TSCH_NFIX) begin
            per_q[idx[3:0]] <= reg_wdata_i;
          end
        end
        `TSCH_REG_SETV: begin
          if (idx < `TSCH_NINT) begin
            setv_q[idx[3:0]] <= reg_wdata_i[15:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Register reads; data stand only in the cycle after the strobe.
  always @* begin
    pend_w = 64'h0;
    busy_w = 64'h0;
    pend_w[NT-1:0] = pend_q;
    busy_w[NT-1:0] = busy_q;
    rdata_d = 32'h0;
    case (region)
      `TSCH_REG_CTRL: begin
        case (idx)
          `TSCH_IDX_CTRL: rdata_d = {31'h0, run_q};
          `TSCH_IDX_PEND_LO: rdata_d = pend_w[31:0];
          `TSCH_IDX_PEND_HI: rdata_d = pend_w[63:32];
          `TSCH_IDX_BUSY_LO: rdata_d = busy_w[31:0];
          `TSCH_IDX_BUSY_HI: rdata_d = busy_w[63:32];
          default: rdata_d = 32'h0;
        endcase
      end
      `TSCH_REG_CFG: begin
        if (idx < NT) begin
          rdata_d = {20'h0, cfg_q[idx]};
        end
      end
      `TSCH_REG_PERIOD: begin
        if (idx < `TSCH_NFIX) begin
          rdata_d = per_q[idx[3:0]];
        end
      end
      `TSCH_REG_SETV: begin
        if (idx < `TSCH_NINT) begin
          rdata_d = {16'h0, setv_q[idx[3:0]]};
        end
      end
      default: rdata_d = 32'h0;
    endcase
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h0;
    end
  end
endmodule

// ===== tb/tsch_scheduler_asserts.sv
// Port checks for the task request scheduler.
`timescale 1ns/100ps
module tsch_scheduler_asserts #(
  parameter NCH = 4
) (
  // Clock and reset.
  input wire core_clk_i,
  input wire rst_n_i,
  // Register port.
  input wire [9:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  // Executor side.
  input wire task_req_o,
  input wire [5:0] task_num_o,
  input wire task_ack_i,
  input wire run_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take;
    task_req_o && task_ack_i;
  endsequence
  sequence s_stopped;
    !run_o [*4] ##0 !task_req_o;
  endsequence
  chk_reset_quiet: assert property ($rose(rst_n_i) |-> !task_req_o && !run_o)
    else $error("outputs busy after reset");
  chk_stop_quiet: assert property (s_stopped |=> !task_req_o)
    else $error("new offer while stopped");
  chk_offer_hold: assert property (task_req_o && !task_ack_i |=> task_req_o)
    else $error("offer dropped without ack");
  chk_take_clear: assert property (s_take |=> !task_req_o ||
    task_num_o != $past(task_num_o))
    else $error("taken task offered again");
  chk_num_range: assert property (task_req_o |-> task_num_o < 40 + NCH)
    else $error("offered number out of range");
  chk_run_write: assert property (reg_wr_i && reg_addr_i[9:2] == 8'h00 |=>
    run_o == $past(reg_wdata_i[0]))
    else $error("mode bit not written");
  chk_ctrl_read: assert property (reg_rd_i && reg_addr_i[9:2] == 8'h00 |=>
    reg_rdata_o == {31'h0, $past(run_o)})
    else $error("mode bit read wrong");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule
bind tsch_scheduler tsch_scheduler_asserts #(.NCH(NCH)) tsch_scheduler_asserts_i (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .task_req_o(task_req_o),
  .task_num_o(task_num_o), .task_ack_i(task_ack_i), .run_o(run_o));

// ===== tb/tsch_exec_model.sv
// Task executor model: takes offered tasks and reports them finished.
`timescale 1ns/100ps
module tsch_exec_model (
  // Clock and reset.
  input wire core_clk_i,
  input wire rst_n_i,
  // Bench control.
  input wire go_i,
  input wire [7:0] dly_i,
  // Scheduler side.
  input wire task_req_i,
  input wire [5:0] task_num_i,
  output reg task_ack_o,
  output reg task_done_o,
  output reg [5:0] task_done_num_o
);
  reg [7:0] cnt_q;
  reg [5:0] cur_q;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      task_ack_o <= 1'b0;
      task_done_o <= 1'b0;
      task_done_num_o <= 6'h00;
      cnt_q <= 8'h00;
      cur_q <= 6'h00;
    end else begin
      task_ack_o <= 1'b0;
      task_done_o <= 1'b0;
      task_done_num_o <= ~cur_q;
      if (task_ack_o) begin
        cur_q <= task_num_i;
        cnt_q <= dly_i + 8'h01;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          task_done_o <= 1'b1;
          task_done_num_o <= cur_q;
        end
      end else if (go_i && task_req_i && !task_done_o) begin
        task_ack_o <= 1'b1;
      end
    end
  end
endmodule

// ===== tb/tsch_scheduler_tb_top.sv
// Self-checking bench for the task request scheduler.
`timescale 1ns/100ps
module tsch_scheduler_tb_top;
  reg core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, scan_end_i, go;
  reg [9:0] reg_addr_i;
  reg [31:0] reg_wdata_i, rd_v, r;
  reg [15:0] in_word0_i, dev_bit_i, p, b;
  reg [15:0] sv [0:4];
  reg [255:0] dev_word_i;
  reg [127:0] cnt_val_i, cnt_set0_i;
  reg [7:0] dly;
  reg [63:0] pe, ex;
  wire [31:0] reg_rdata_o;
  wire task_req_o, task_ack_i, task_done_i, run_o;
  wire [5:0] task_num_o, task_done_num_i;
  integer seed, err_total, checked, i, k;
  tsch_scheduler #(.NCH(4), .MS_CYCLES(20), .CNT_CHK_CYCLES(16))
    tsch_scheduler_i (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .in_word0_i, .dev_bit_i,
    .dev_word_i, .scan_end_i, .cnt_val_i, .cnt_set0_i, .task_req_o,
    .task_num_o, .task_ack_i, .task_done_i, .task_done_num_i, .run_o);
  tsch_exec_model tsch_exec_model_i (.core_clk_i, .rst_n_i, .go_i(go),
    .dly_i(dly), .task_req_i(task_req_o), .task_num_i(task_num_o),
    .task_ack_o(task_ack_i), .task_done_o(task_done_i),
    .task_done_num_o(task_done_num_i));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task stop_test;
    begin
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  task chk(input string n, input [63:0] e, input [63:0] s);
    begin
      checked = checked + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task wr(input [9:0] a, input [31:0] d);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [9:0] a);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      rd_v = reg_rdata_o;
    end
  endtask
  task rdpend;
    begin
      rd(10'h004);
      pe[31:0] = rd_v;
      rd(10'h008);
      pe[63:32] = rd_v;
    end
  endtask
  task cfg(input [5:0] n, input [2:0] pr, input [2:0] c, input wt,
    input [3:0] s);
    wr({n, 2'b00} + 10'h100, {20'h0, s, wt, c, 1'b1, pr});
  endtask
  task scan;
    begin
      @(posedge core_clk_i);
      scan_end_i <= 1'b1;
      @(posedge core_clk_i);
      scan_end_i <= 1'b0;
    end
  endtask
  task wack(input [5:0] n);
    begin
      k = 0;
      while (task_ack_i !== 1'b1 && k < 400) begin
        @(negedge core_clk_i);
        k = k + 1;
      end
      chk("taken", {58'h0, n}, {58'h0, task_num_o});
      if (k >= 400) begin
        err_total = err_total + 1;
        stop_test;
      end
      @(negedge core_clk_i);
    end
  endtask
  function fbit(input [2:0] c, input pv, input nv);
    case (c)
      3'h0: fbit = !pv && nv;
      3'h1: fbit = pv && !nv;
      3'h2: fbit = pv != nv;
      3'h3: fbit = nv;
      default: fbit = !nv;
    endcase
  endfunction
  function fword(input [2:0] c, input [15:0] w, input [15:0] s);
    case (c)
      3'h0: fword = w < s;
      3'h1: fword = w <= s;
      3'h2: fword = w == s;
      3'h3: fword = w >= s;
      default: fword = w > s;
    endcase
  endfunction
  initial begin
    seed = 19399;
    err_total = 0;
    checked = 0;
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    scan_end_i = 1'b0;
    go = 1'b0;
    dly = 8'd2;
    reg_addr_i = 10'h000;
    reg_wdata_i = 32'h0;
    in_word0_i = 16'h0;
    dev_bit_i = 16'h0;
    dev_word_i = 256'h0;
    cnt_val_i = 128'h0;
    cnt_set0_i = ~128'h0;
    cyc(2);
    rst_n_i <= 1'b1;
    rd(10'h100);
    chk("cfg_rst", 64'h7, {32'h0, rd_v});
    wr(10'h3fc, 32'hffff);
    rd(10'h3fc);
    chk("unmapped", 64'h0, {32'h0, rd_v});
    cfg(6'd16, 3'h4, 3'h0, 1'b0, 4'h0);
    cfg(6'd17, 3'h3, 3'h1, 1'b0, 4'h1);
    cfg(6'd18, 3'h5, 3'h2, 1'b0, 4'h2);
    in_word0_i <= 16'h0100;
    cyc(12);
    in_word0_i <= 16'h0000;
    cyc(12);
    rdpend;
    chk("stop_pend", 64'h0, pe);
    wr(10'h000, 32'h1);
    in_word0_i <= 16'h07ff;
    cyc(8);
    rdpend;
    chk("rise", 64'h5_0000, pe);
    in_word0_i <= 16'h0000;
    cyc(8);
    rdpend;
    chk("fall", 64'h7_0000, pe);
    go <= 1'b1;
    wack(6'd17);
    wack(6'd16);
    wack(6'd18);
    go <= 1'b0;
    cyc(10);
    cfg(6'd0, 3'h2, 3'h0, 1'b0, 4'h0);
    wr(10'h200, 32'h3);
    cyc(30);
    rdpend;
    chk("fix_early", 64'h0, pe);
    cyc(40);
    rdpend;
    chk("fix_due", 64'h1, pe);
    wr(10'h200, 32'h1);
    dly <= 8'd100;
    go <= 1'b1;
    wack(6'd0);
    go <= 1'b0;
    cyc(50);
    rdpend;
    chk("fix_drop", 64'h0, pe);
    rd(10'h00c);
    chk("busy", 64'h1, {32'h0, rd_v});
    wr(10'h000, 32'h0);
    cyc(150);
    rdpend;
    chk("fix_hold", 64'h0, pe);
    wr(10'h000, 32'h1);
    cyc(25);
    rdpend;
    chk("fix_resume", 64'h1, pe);
    dly <= 8'd2;
    go <= 1'b1;
    wack(6'd0);
    wr(10'h200, 32'h0);
    cyc(40);
    go <= 1'b0;
    cyc(10);
    for (i = 0; i < 5; i = i + 1) begin
      cfg(6'd24 + i[5:0], 3'h3, i[2:0], 1'b1, i[3:0]);
      cfg(6'd29 + i[5:0], 3'h3, i[2:0], 1'b0, i[3:0]);
      r = $random(seed);
      sv[i] = {1'b0, r[14:0]};
      wr(10'h300 + i[9:0] * 10'h4, {16'h0, sv[i]});
    end
    repeat (4) begin
      r = $random(seed);
      p = r[15:0];
      b = r[31:16];
      dev_bit_i <= p;
      scan;
      go <= 1'b1;
      cyc(120);
      go <= 1'b0;
      cyc(10);
      dev_bit_i <= ~b;
      for (i = 0; i < 5; i = i + 1) begin
        r = $random(seed);
        dev_word_i[16*i+:16] <= (i == 2 && r[31]) ? sv[2] : {1'b0, r[14:0]};
      end
      cyc(3);
      dev_bit_i <= b;
      rdpend;
      chk("no_scan", 64'h0, pe);
      scan;
      ex = 64'h0;
      for (i = 0; i < 5; i = i + 1) begin
        ex[24+i] = fword(i[2:0], dev_word_i[16*i+:16], sv[i]);
        ex[29+i] = fbit(i[2:0], p[i], b[i]);
      end
      rdpend;
      chk("device", ex, pe);
    end
    go <= 1'b1;
    cyc(120);
    go <= 1'b0;
    cyc(10);
    cfg(6'd40, 3'h2, 3'h0, 1'b0, 4'h0);
    r = $random(seed);
    cnt_set0_i[31:0] <= r;
    cnt_val_i[31:0] <= ~r;
    cyc(40);
    rdpend;
    chk("cnt_ne", 64'h0, pe);
    cnt_val_i[31:0] <= r;
    cyc(20);
    rdpend;
    chk("cnt_eq", 64'h100_0000_0000, pe);
    go <= 1'b1;
    wack(6'd40);
    go <= 1'b0;
    cnt_val_i[31:0] <= ~r;
    cyc(40);
    wr(10'h000, 32'h0);
    cnt_val_i[31:0] <= r;
    cyc(40);
    rdpend;
    chk("cnt_stop", 64'h0, pe);
    stop_test;
  end
endmodule
